// file: i2cw_defines.svh
// i2cw_defines.svh: constants shared by both ends of the register-write link.
// assumes inclusion by bare name from the package and the design modules.
`ifndef I2CW_DEFINES_SVH
`define I2CW_DEFINES_SVH

`define I2CW_CLK_PERIOD_NS 5          // system clock period, ns
`define I2CW_SCL_PERIOD_NS 2500       // bus clock period made by the master, ns (400 kHz)
`define I2CW_RW_WRITE      1'b0       // direction bit value for a write
`define I2CW_PTR_RESET     8'h00      // register pointer after reset
`define I2CW_BYTE_LAST     4'h8       // bit count that closes a byte
`define I2CW_DEV_ADDR      7'h2A      // bus address, arbitrary value
`define I2CW_NUM_REGS      9'h040     // registers that exist, plain default

`endif

// file: i2cw_pkg.sv
// i2cw_pkg.sv: state types for both ends of the register-write link.
// assumes i2cw_defines.svh sits in the same folder.
`include "i2cw_defines.svh"

package i2cw_pkg;

    // slave phases of a write transfer
    typedef enum logic [2:0] {
        DEV_IDLE,
        DEV_ADDR,
        DEV_INDEX,
        DEV_DATA,
        DEV_SKIP
    } i2cw_dev_st_t;

    // master bit-engine phases
    typedef enum logic [1:0] {
        HST_IDLE,
        HST_START,
        HST_BIT,
        HST_STOP
    } i2cw_hst_st_t;

    // whole slave state
    typedef struct packed {
        logic [1:0]   sclSync;      // scl synchroniser
        logic [1:0]   sdaSync;      // sda synchroniser
        logic         sclPrev;      // scl one cycle older
        logic         sdaPrev;      // sda one cycle older
        i2cw_dev_st_t st;
        logic         ackPh;        // inside the ninth clock
        logic [3:0]   bitCnt;
        logic [7:0]   shift;
        logic [7:0]   ptr;          // register pointer
        logic         sdaOe;
        logic         wrEn;
        logic [7:0]   wrAddr;
        logic [7:0]   wrData;
        logic         inFrame;
    } i2cw_dev_s_t;

    // whole master state
    typedef struct packed {
        logic [1:0]   sdaSync;      // sda synchroniser
        i2cw_hst_st_t st;
        logic [1:0]   ph;           // quarter of a bus clock
        logic [15:0]  qCnt;         // quarter divider
        logic [3:0]   bitN;         // 0..7 data, 8 acknowledge
        logic [7:0]   shift;
        logic [1:0]   kind;         // 0 address, 1 index, 2 data
        logic [7:0]   left;         // data bytes still to send
        logic         sclOe;
        logic         sdaOe;
        logic         busy;
        logic         done;
        logic         nack;
        logic         take;
    } i2cw_hst_s_t;

endpackage

// file: i2cw_bus_if.sv
// i2cw_bus_if.sv: the two-wire bus between master and slave.
// assumes open-drain wires with pull-ups; each end drives low only.
`timescale 1ns/1ps
`default_nettype none

interface i2cw_bus_if;
    logic sclHostOut;   // master clock drive value
    logic sclHostOe;    // master pulls scl
    logic sdaHostOut;   // master data drive value
    logic sdaHostOe;    // master pulls sda
    logic sdaDevOut;    // slave data drive value
    logic sdaDevOe;     // slave pulls sda
    logic scl;          // resolved clock line
    logic sda;          // resolved data line

    // wired-and with pull-up
    assign scl = !(sclHostOe && !sclHostOut);
    assign sda = !((sdaHostOe && !sdaHostOut) || (sdaDevOe && !sdaDevOut));

    modport dev  (input scl, sda, output sdaDevOut, sdaDevOe);
    modport host (input scl, sda, output sclHostOut, sclHostOe, sdaHostOut, sdaHostOe);
endinterface

`default_nettype wire

// file: i2cw_slave.sv
// i2cw_slave.sv: write side of the register port, bus slave end.
// assumes a master that makes scl far slower than clk (many clks per quarter).
// assumes the register file shares clk and stores on wrEn.
// assumes ce also freezes whatever moves the bus, or stays high.
// Operation
// - master opens each write with START
// - write address, bit zero, slave acknowledges
// - index byte loads the register pointer
// - pointer advances by one per stored byte
// - missing register: not-acknowledge, pointer kept
// - data byte stored at pointer, acknowledged
// - master ends the write with STOP
// - pointer wraps from 255 to 0
// - pointer survives the end of transfer
`timescale 1ns/1ps
`default_nettype none
`include "i2cw_defines.svh"

module i2cw_slave #(
    parameter logic [6:0] DEV_ADDR = `I2CW_DEV_ADDR,  // arbitrary value
    parameter logic [8:0] NUM_REGS = `I2CW_NUM_REGS   // indices below this exist
) (
    // clock, reset, enable
    input  wire logic  clk,
    input  wire logic  resetn,
    input  wire logic  ce,
    // bus
    i2cw_bus_if.dev    bus,
    // register write strobe
    output logic       wrEn,
    output logic [7:0] wrAddr,
    output logic [7:0] wrData,
    // status
    output logic [7:0] regPtr,
    output logic       inFrame
);

    // every flop of the slave lives in this one struct
    i2cw_pkg::i2cw_dev_s_t s_r;     // all state
    i2cw_pkg::i2cw_dev_s_t s_nxt;   // next state

    // strobes decoded from registered state only
    logic sclRise;                  // synced scl rising
    logic sclFall;                  // synced scl falling
    logic startSeen;                // sda falls while scl high
    logic stopSeen;                 // sda rises while scl high
    logic idxOk;                    // index byte names a register
    logic ptrOk;                    // pointer names a register

    // edges look only at the second stage and its delayed copy
    // start and stop want scl high on both samples, so an scl
    // fall and an sda move in one cycle is never either
    // a rising scl shifts a bit, a falling one closes byte or ack
    // nine-bit compares let NUM_REGS of 256 mean all exist
    assign sclRise   = s_r.sclSync[1] && !s_r.sclPrev;
    assign sclFall   = !s_r.sclSync[1] && s_r.sclPrev;
    assign startSeen = s_r.sclSync[1] && s_r.sclPrev && !s_r.sdaSync[1] && s_r.sdaPrev;
    assign stopSeen  = s_r.sclSync[1] && s_r.sclPrev && s_r.sdaSync[1] && !s_r.sdaPrev;
    assign idxOk     = {1'b0, s_r.shift} < NUM_REGS;
    assign ptrOk     = {1'b0, s_r.ptr} < NUM_REGS;

    // byte walk, in enabled clk cycles:
    //   scl rise 1..8: a bit shifts in, msb first
    //   scl fall 8: answer decided, ack driven or not
    //   scl rise 9: the master samples the answer
    //   scl fall 9: line released, next byte at zero
    // line events arrive three cycles late (two sync
    // stages plus the delay stage), so a bus quarter
    // must outlast three enabled cycles
    // start and stop override all, so a lost bit
    // costs at most one refused frame, never a hang
    // refusals:
    //   foreign address or read bit: nack, skip
    //   index at or above NUM_REGS: nack, ptr kept
    //   data with ptr at or above NUM_REGS: nack
    // a refused frame is not resumed; the master
    // must stop and start it again
    // pointer life:
    //   loaded from the index byte on its ack
    //   bumped after each stored byte, wraps at 255
    //   left alone by start and stop
    // so a later current-address read picks up
    // where this write ended
    // next-state logic
    always_comb begin
        s_nxt         = s_r;
        s_nxt.sclSync = {s_r.sclSync[0], bus.scl};
        s_nxt.sdaSync = {s_r.sdaSync[0], bus.sda};
        s_nxt.sclPrev = s_r.sclSync[1];
        s_nxt.sdaPrev = s_r.sdaSync[1];
        s_nxt.wrEn    = 1'b0;           // strobe lasts one enabled cycle, held while ce is low
        // wrAddr and wrData keep their value between strobes

        // priority: line conditions, then the ninth clock, then bits
        if (startSeen) begin
            // a start anywhere, repeated too, restarts the byte engine
            // a half-received byte is dropped
            s_nxt.st      = i2cw_pkg::DEV_ADDR;
            s_nxt.ackPh   = 1'b0;
            s_nxt.bitCnt  = 4'h0;
            s_nxt.sdaOe   = 1'b0;
            s_nxt.inFrame = 1'b1;
        end else if (stopSeen) begin
            // pointer is left alone so a later read resumes here
            // a stop in mid-byte drops the partial byte
            s_nxt.st      = i2cw_pkg::DEV_IDLE;
            s_nxt.ackPh   = 1'b0;
            s_nxt.sdaOe   = 1'b0;
            s_nxt.inFrame = 1'b0;
        end else if (s_r.ackPh) begin
            // ninth clock: release the line once it falls
            // the ninth rise needs no work: the answer already stands
            if (sclFall) begin
                s_nxt.ackPh  = 1'b0;
                s_nxt.sdaOe  = 1'b0;
                s_nxt.bitCnt = 4'h0;
            end
        end else begin
            case (s_r.st)
                i2cw_pkg::DEV_ADDR,
                i2cw_pkg::DEV_INDEX,
                i2cw_pkg::DEV_DATA: begin
                    if (sclRise && s_r.bitCnt != `I2CW_BYTE_LAST) begin
                        // msb first, data is stable while scl is high
                        // the ninth rise is ignored: bitCnt already reads eight
                        s_nxt.shift  = {s_r.shift[6:0], s_r.sdaSync[1]};
                        s_nxt.bitCnt = s_r.bitCnt + 4'h1;
                    end else if (sclFall && s_r.bitCnt == `I2CW_BYTE_LAST) begin
                        // answer after the eighth clock falls
                        // so sda never moves while scl is high
                        s_nxt.ackPh = 1'b1;
                        s_nxt.st    = i2cw_pkg::DEV_SKIP;    // default: refuse
                        case (s_r.st)
                            i2cw_pkg::DEV_ADDR: begin
                                // own address with write direction only
                                // read direction is not served, so refused
                                if (s_r.shift[7:1] == DEV_ADDR && s_r.shift[0] == `I2CW_RW_WRITE) begin
                                    s_nxt.sdaOe = 1'b1;
                                    s_nxt.st    = i2cw_pkg::DEV_INDEX;
                                end
                            end
                            i2cw_pkg::DEV_INDEX: begin
                                // nonexistent index: nack, pointer kept
                                // a refused index ends the frame: no data lands
                                if (idxOk) begin
                                    s_nxt.sdaOe = 1'b1;
                                    s_nxt.ptr   = s_r.shift;
                                    s_nxt.st    = i2cw_pkg::DEV_DATA;
                                end
                            end
                            i2cw_pkg::DEV_DATA: begin
                                // store, then bump; 8-bit add wraps 255 to 0
                                // one edge for both, so wrAddr is the old pointer
                                if (ptrOk) begin
                                    s_nxt.sdaOe  = 1'b1;
                                    s_nxt.wrEn   = 1'b1;
                                    s_nxt.wrAddr = s_r.ptr;
                                    s_nxt.wrData = s_r.shift;
                                    s_nxt.ptr    = s_r.ptr + 8'h01;
                                    s_nxt.st     = i2cw_pkg::DEV_DATA;
                                end
                            end
                            default: begin
                                // unreachable: only byte phases get here
                                s_nxt.st = i2cw_pkg::DEV_SKIP;
                            end
                        endcase
                    end
                end
                default: begin
                    // idle or refused: wait for start or stop
                    // bits clocked here are dropped on purpose
                    s_nxt.bitCnt = 4'h0;
                end
            endcase
        end
    end

    // state register, frozen while ce is low
    // reset loads the line stages with the idle level, so no
    // false start or stop follows release
    // ce low holds the line stages too: no edge is lost
    // only resetn clears the pointer
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_r         <= '0;
            s_r.sclSync <= 2'h3;        // idle bus reads high
            s_r.sdaSync <= 2'h3;
            s_r.sclPrev <= 1'b1;
            s_r.sdaPrev <= 1'b1;
            s_r.st      <= i2cw_pkg::DEV_IDLE;
            s_r.ptr     <= `I2CW_PTR_RESET;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // open-drain: value is always low, enable decides
    // every output below but sdaDevOut is a plain copy of a state flop
    assign bus.sdaDevOut = 1'b0;
    assign bus.sdaDevOe  = s_r.sdaOe;
    assign wrEn          = s_r.wrEn;
    assign wrAddr        = s_r.wrAddr;
    assign wrData        = s_r.wrData;
    assign regPtr        = s_r.ptr;
    assign inFrame       = s_r.inFrame;

endmodule // i2cw_slave

`default_nettype wire

// file: i2cw_master.sv
// i2cw_master.sv: bus master end issuing register writes.
// assumes the slave never stretches scl; quarter period set by QUARTER.
`timescale 1ns/1ps
`default_nettype none
`include "i2cw_defines.svh"

module i2cw_master #(
    // quarter of the bus clock in clk cycles, rounded down
    parameter logic [15:0] QUARTER = 16'((`I2CW_SCL_PERIOD_NS / `I2CW_CLK_PERIOD_NS) / 4)
) (
    // clock, reset, enable
    input  wire logic  clk,
    input  wire logic  resetn,
    input  wire logic  ce,
    // bus
    i2cw_bus_if.host   bus,
    // command
    input  wire logic       go,
    input  wire logic [6:0] devAddr,
    input  wire logic [7:0] regIdx,
    input  wire logic [7:0] byteCount,
    input  wire logic [7:0] dataIn,
    // status
    output logic       dataTake,
    output logic       busy,
    output logic       done,
    output logic       nackSeen
);

    i2cw_pkg::i2cw_hst_s_t s_r;     // all state
    i2cw_pkg::i2cw_hst_s_t s_nxt;   // next state
    logic                  tick;    // quarter boundary

    assign tick = (s_r.qCnt == QUARTER - 16'h0001);

    // next-state logic
    always_comb begin
        s_nxt         = s_r;
        s_nxt.sdaSync = {s_r.sdaSync[0], bus.sda};
        s_nxt.done    = 1'b0;
        s_nxt.take    = 1'b0;
        s_nxt.qCnt    = (tick || !s_r.busy) ? 16'h0000 : s_r.qCnt + 16'h0001;
        if (tick) begin
            s_nxt.ph = s_r.ph + 2'h1;
        end

        case (s_r.st)
            i2cw_pkg::HST_IDLE: begin
                // load address byte, write direction
                if (go) begin
                    s_nxt.st    = i2cw_pkg::HST_START;
                    s_nxt.busy  = 1'b1;
                    s_nxt.nack  = 1'b0;
                    s_nxt.ph    = 2'h0;
                    s_nxt.shift = {devAddr, `I2CW_RW_WRITE};
                    s_nxt.kind  = 2'h0;
                    s_nxt.left  = byteCount;
                    s_nxt.bitN  = 4'h0;
                end
            end
            i2cw_pkg::HST_START: begin
                // sda falls in quarter 1 while scl high, scl falls in 3
                if (tick && s_r.ph == 2'h1) begin
                    s_nxt.sdaOe = 1'b1;
                end
                if (tick && s_r.ph == 2'h3) begin
                    s_nxt.sclOe = 1'b1;
                    s_nxt.st    = i2cw_pkg::HST_BIT;
                end
            end
            i2cw_pkg::HST_BIT: begin
                if (tick) begin
                    case (s_r.ph)
                        2'h0: begin
                            // set data while scl low; release for ack
                            s_nxt.sdaOe = (s_r.bitN == `I2CW_BYTE_LAST) ? 1'b0 : !s_r.shift[7];
                        end
                        2'h1: begin
                            s_nxt.sclOe = 1'b0;
                        end
                        2'h2: begin
                            // ack sample in mid-high
                            if (s_r.bitN == `I2CW_BYTE_LAST && s_r.sdaSync[1]) begin
                                s_nxt.nack = 1'b1;
                            end
                        end
                        default: begin
                            s_nxt.sclOe = 1'b1;
                            s_nxt.shift = {s_r.shift[6:0], 1'b0};
                            s_nxt.bitN  = s_r.bitN + 4'h1;
                            if (s_r.bitN == `I2CW_BYTE_LAST) begin
                                s_nxt.bitN = 4'h0;
                                if (s_r.nack || (s_r.kind != 2'h0 && s_r.left == 8'h00)) begin
                                    // last byte acknowledged, or refused
                                    s_nxt.st    = i2cw_pkg::HST_STOP;
                                    s_nxt.sdaOe = 1'b1;
                                end else if (s_r.kind == 2'h0) begin
                                    s_nxt.shift = regIdx;
                                    s_nxt.kind  = 2'h1;
                                end else begin
                                    s_nxt.shift = dataIn;
                                    s_nxt.take  = 1'b1;
                                    s_nxt.kind  = 2'h2;
                                    s_nxt.left  = s_r.left - 8'h01;
                                end
                            end
                        end
                    endcase
                end
            end
            i2cw_pkg::HST_STOP: begin
                // scl rises in quarter 1, sda rises in 3
                if (tick && s_r.ph == 2'h1) begin
                    s_nxt.sclOe = 1'b0;
                end
                if (tick && s_r.ph == 2'h3) begin
                    s_nxt.sdaOe = 1'b0;
                    s_nxt.st    = i2cw_pkg::HST_IDLE;
                    s_nxt.busy  = 1'b0;
                    s_nxt.done  = 1'b1;
                end
            end
            default: begin
                s_nxt.st = i2cw_pkg::HST_IDLE;
            end
        endcase
    end

    // state register, frozen while ce is low
    always_ff @(posedge clk) begin
        if (!resetn) begin
            s_r         <= '0;
            s_r.sdaSync <= 2'h3;
            s_r.st      <= i2cw_pkg::HST_IDLE;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    // open-drain drives
    assign bus.sclHostOut = 1'b0;
    assign bus.sclHostOe  = s_r.sclOe;
    assign bus.sdaHostOut = 1'b0;
    assign bus.sdaHostOe  = s_r.sdaOe;
    assign dataTake       = s_r.take;
    assign busy           = s_r.busy;
    assign done           = s_r.done;
    assign nackSeen       = s_r.nack;

endmodule // i2cw_master

`default_nettype wire

// file: i2cw_props.sv
// i2cw_props.sv: concurrent checks on the first link of the bench.
// assumes the bench hands in the resolved lines and the slave's user side.
`timescale 1ns/1ps
`default_nettype none

module i2cw_props #(
    parameter logic [8:0] NUM_REGS = 9'h040  // indices below this exist
) (
    // clock, reset and the shared enable
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       ce,
    // resolved lines and slave drive
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       sdaDevOe,
    // slave user side
    input  wire logic       wrEn,
    input  wire logic [7:0] wrAddr,
    input  wire logic [7:0] regPtr,
    input  wire logic       inFrame
);
    // one domain, so one clock and one disable for all
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_frame_open_start: assert property ($rose(inFrame) |-> scl)
        else $error("frame opened while scl low");
    a_frame_close_stop: assert property ($fell(inFrame) |-> scl && sda)
        else $error("frame closed without stop");
    // the slave may only move sda while scl is low
    a_ack_moves_low: assert property ($changed(sdaDevOe) |-> !scl)
        else $error("slave moved sda while scl high");
    a_ack_holds_line: assert property (sdaDevOe && $rose(scl) |-> !sda)
        else $error("acknowledge not on the line");
    a_store_is_acked: assert property (wrEn |-> sdaDevOe)
        else $error("store without acknowledge");
    a_store_one_pulse: assert property (wrEn && ce |=> !wrEn)
        else $error("store strobe longer than one cycle");
    a_ptr_step_one: assert property (wrEn |-> regPtr == wrAddr + 8'h01)
        else $error("pointer did not advance by one");
    a_store_exists: assert property (wrEn |-> {1'b0, wrAddr} < NUM_REGS)
        else $error("store to a missing register");
    a_ptr_on_ack: assert property ($changed(regPtr) |-> $rose(sdaDevOe))
        else $error("pointer moved without acknowledge");
    a_ptr_kept_idle: assert property (!inFrame |=> $stable(regPtr))
        else $error("pointer moved between transfers");
endmodule // i2cw_props

`default_nettype wire

// file: i2c_register_write_slave_tb_top.sv
// i2c_register_write_slave_tb_top.sv: two master/slave pairs share one command.
// assumes pair A has 64 registers, pair B all 256; both see the same bytes.
`timescale 1ns/1ps
`default_nettype none
`include "i2cw_defines.svh"

module i2c_register_write_slave_tb_top;
    logic        clk;          // system clock, 5 ns
    logic        resetn;       // sync reset, active low
    logic        go;           // command strobe to both masters
    logic [6:0]  devAddr;
    logic [7:0]  regIdx;
    logic [7:0]  byteCount;
    logic [7:0]  dat [0:7];    // bytes of the current transfer
    logic [2:0]  kA, kB;       // next byte each master reads
    logic        takeA, takeB, busyA, busyB, doneA, doneB, nackA, nackB;
    logic        wrEnA, wrEnB, frameA, frameB;
    logic [7:0]  wrAddrA, wrAddrB, wrDataA, wrDataB, ptrA, ptrB;
    logic [7:0]  mPtrA, mPtrB; // model pointers
    logic [15:0] qA [$];       // expected stores, pair A
    logic [15:0] qB [$];       // expected stores, pair B
    logic [31:0] lfsr;
    logic [31:0] ceRnd;        // clock-enable generator state
    logic        ce;           // shared enable, random
    logic        tmo;          // a wait ran out
    int          errors, n_compared;

    i2cw_bus_if busA ();
    i2cw_bus_if busB ();

    // pair A: small map, exercises refusals
    i2cw_master #(.QUARTER(16'h0006)) i2cw_master_i (.clk(clk), .resetn(resetn), .ce(ce), .bus(busA),
        .go(go), .devAddr(devAddr), .regIdx(regIdx), .byteCount(byteCount), .dataIn(dat[kA]),
        .dataTake(takeA), .busy(busyA), .done(doneA), .nackSeen(nackA));
    i2cw_slave #(.NUM_REGS(9'h040)) i2cw_slave_i (.clk(clk), .resetn(resetn), .ce(ce), .bus(busA),
        .wrEn(wrEnA), .wrAddr(wrAddrA), .wrData(wrDataA), .regPtr(ptrA), .inFrame(frameA));
    // pair B: full map, exercises the wrap
    i2cw_master #(.QUARTER(16'h0006)) i2cw_master_full_i (.clk(clk), .resetn(resetn), .ce(ce), .bus(busB),
        .go(go), .devAddr(devAddr), .regIdx(regIdx), .byteCount(byteCount), .dataIn(dat[kB]),
        .dataTake(takeB), .busy(busyB), .done(doneB), .nackSeen(nackB));
    i2cw_slave #(.NUM_REGS(9'h100)) i2cw_slave_full_i (.clk(clk), .resetn(resetn), .ce(ce), .bus(busB),
        .wrEn(wrEnB), .wrAddr(wrAddrB), .wrData(wrDataB), .regPtr(ptrB), .inFrame(frameB));

    i2cw_props #(.NUM_REGS(9'h040)) i2cw_props_i (.clk(clk), .resetn(resetn), .ce(ce), .scl(busA.scl),
        .sda(busA.sda), .sdaDevOe(busA.sdaDevOe), .wrEn(wrEnA), .wrAddr(wrAddrA), .regPtr(ptrA),
        .inFrame(frameA));

    // free-running clock
    always #2.5 clk = ~clk;

    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // random enable for all four ends; frozen edges stretch every pulse
    always @(posedge clk) begin
        #1;
        ceRnd = lfsr_next(ceRnd);
        ce = (ceRnd[1:0] != 2'h0);
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("errors=%0d compared=%0d", errors, n_compared);
        if (errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // an empty queue means the store was not expected at all
    task automatic store(ref logic [15:0] q[$], input logic [15:0] got);
        if (q.size() == 0)
            chk(32'(got), 32'h0001_0000);
        else
            chk(32'(got), 32'(q.pop_front()));
    endtask

    // expected stores, pointer and refusal for one map size
    task automatic plan(input logic [8:0] nr, input logic [7:0] idx, input logic [7:0] n, input logic okAddr,
                        inout logic [7:0] ptr, output logic nk, ref logic [15:0] q[$]);
        logic [7:0] p;
        nk = !okAddr || ({1'b0, idx} >= nr);
        p = idx;
        if (!nk)
            ptr = idx;
        for (int j = 0; j < n && !nk; j++) begin
            if ({1'b0, p} >= nr) begin
                nk = 1'b1;
            end else begin
                q.push_back({p, dat[j]});
                p = p + 8'h01;
                ptr = p;
            end
        end
    endtask

    // byte hand-off and store monitor; a pulse held over frozen edges counts once
    always @(posedge clk) begin
        if (ce === 1'b1) begin
            if (takeA === 1'b1)
                kA <= kA + 3'h1;
            if (takeB === 1'b1)
                kB <= kB + 3'h1;
            if (wrEnA === 1'b1)
                store(qA, {wrAddrA, wrDataA});
            if (wrEnB === 1'b1)
                store(qB, {wrAddrB, wrDataB});
        end
    end

    // one whole write on both pairs, then end-of-transfer checks
    task automatic xfer(input logic [6:0] addr, input logic [7:0] idx, input logic [7:0] n);
        logic nkA, nkB, sA, sB;
        int   nEn;
        if (tmo)
            return;
        @(posedge clk);
        #1;
        for (int j = 0; j < 8; j++) begin
            lfsr = lfsr_next(lfsr);
            dat[j] = lfsr[7:0];
        end
        plan(9'h040, idx, n, addr == `I2CW_DEV_ADDR, mPtrA, nkA, qA);
        plan(9'h100, idx, n, addr == `I2CW_DEV_ADDR, mPtrB, nkB, qB);
        devAddr = addr;
        regIdx = idx;
        byteCount = n;
        kA = 3'h0;
        kB = 3'h0;
        go = 1'b1;
        // hold go until both masters take it; a frozen edge takes nothing
        for (int i = 0; i < 64 && !(busyA === 1'b1 && busyB === 1'b1); i++) begin
            @(posedge clk);
            #1;
        end
        go = 1'b0;
        sA = 1'b0;
        sB = 1'b0;
        for (int i = 0; i < 30000 && !(sA && sB); i++) begin
            @(posedge clk);
            #1;
            sA = sA || (doneA === 1'b1);
            sB = sB || (doneB === 1'b1);
        end
        if (!(sA && sB)) begin
            errors++;
            tmo = 1'b1;
            return;
        end
        // the stop reaches the slave three enabled edges after done
        nEn = 0;
        for (int i = 0; i < 64 && nEn < 4; i++) begin
            @(posedge clk);
            nEn += (ce === 1'b1) ? 1 : 0;
        end
        #1;
        chk(32'(ptrA), 32'(mPtrA));
        chk(32'(ptrB), 32'(mPtrB));
        chk(32'(nackA), 32'(nkA));
        chk(32'(nackB), 32'(nkB));
        chk(32'(qA.size() + qB.size()), 32'h0);
        chk(32'({frameA, frameB}), 32'h0);
    endtask

    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        go = 1'b0;
        devAddr = 7'h00;
        regIdx = 8'h00;
        byteCount = 8'h01;
        kA = 3'h0;
        kB = 3'h0;
        lfsr = 32'h0000_329E;
        ceRnd = 32'h0000_329E;
        ce = 1'b1;
        tmo = 1'b0;
        errors = 0;
        n_compared = 0;
        mPtrA = 8'h00;
        mPtrB = 8'h00;
        for (int j = 0; j < 8; j++)
            dat[j] = 8'h00;
        repeat (16) @(posedge clk);
        #1 resetn = 1'b1;
        chk(32'({ptrA, ptrB}), 32'h0);
        xfer(`I2CW_DEV_ADDR, 8'h00, 8'h01); // single byte
        xfer(`I2CW_DEV_ADDR, 8'h3E, 8'h04); // runs off the small map mid-transfer
        xfer(`I2CW_DEV_ADDR, 8'h40, 8'h02); // index missing on the small map
        xfer(`I2CW_DEV_ADDR, 8'hFD, 8'h05); // pointer wraps on the full map
        xfer(7'h15, 8'h05, 8'h02); // nobody answers this address
        repeat (12) begin
            lfsr = lfsr_next(lfsr);
            xfer(lfsr[0] ? `I2CW_DEV_ADDR : lfsr[7:1], lfsr[15:8], {6'h00, lfsr[17:16]} + 8'h01);
        end
        close_out();
    end
endmodule // i2c_register_write_slave_tb_top

`default_nettype wire
